// ===== rtl/crac_consts.svh
// Constants for the logic cell register asynchronous control block
`ifndef CRAC_CONSTS_SVH
`define CRAC_CONSTS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define CRAC_CELLS        8
`define CRAC_MODE_W       3

// ****************************************************************
// Register values
// ****************************************************************
`define CRAC_CLEAR_VALUE  1'b0
`define CRAC_PRESET_VALUE 1'b1
`define CRAC_RST_VALUE    1'b0
`define CRAC_RST_RELEASE  1'b1

// ****************************************************************
// Control line selection for clear-only and inverted preset
// ****************************************************************
`define CRAC_SEL_LINE_A   1'b0
`define CRAC_SEL_LINE_B   1'b1

`endif

// ===== rtl/crac_pkg.sv
// Types for the logic cell register asynchronous control block
package crac_pkg;

  // ****************************************************************
  // Asynchronous control modes of one logic cell register
  // ****************************************************************
  typedef enum logic [2:0] {
    crac_mode_none        = 3'h0,
    crac_mode_clear       = 3'h1,
    crac_mode_preset_load = 3'h3,
    crac_mode_preset_inv  = 3'h2,
    crac_mode_clr_pre     = 3'h6,
    crac_mode_load_clr    = 3'h7,
    crac_mode_load_pre    = 3'h5,
    crac_mode_load_only   = 3'h4
  } crac_mode_e;

endpackage : crac_pkg

// ===== rtl/crac_cell_ff.sv
// Storage register of one logic cell with active-low asynchronous clear and preset
`timescale 1ns/10ps
`default_nettype none
`include "crac_consts.svh"

module crac_cell_ff (
  input  wire logic clock,
  input  wire logic clear_low,
  input  wire logic preset_low,
  input  wire logic d,
  output logic      q
);

  logic q_ff;
  logic nxt_q_ff;

  // ****************************************************************
  // Next value
  // ****************************************************************
  always_comb begin
    nxt_q_ff = d;
  end

  // ****************************************************************
  // Register, clear dominates preset
  // ****************************************************************
  always_ff @(posedge clock or negedge clear_low or negedge preset_low) begin
    if (!clear_low) begin
      q_ff <= `CRAC_CLEAR_VALUE;
    end else if (!preset_low) begin
      q_ff <= `CRAC_PRESET_VALUE;
    end else begin
      q_ff <= nxt_q_ff;
    end
  end

  assign q = q_ff;

endmodule : crac_cell_ff
`default_nettype wire

// ===== rtl/crac_ctrl.sv
// Asynchronous clear, preset and load control for the registers of one cell cluster
`timescale 1ns/10ps
`default_nettype none
`include "crac_consts.svh"

module crac_ctrl
  import crac_pkg::*;
#(
  parameter int CELLS = `CRAC_CELLS
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   cluster_ctrl_a,
  input  wire logic                   cluster_ctrl_b,
  input  wire crac_mode_e [CELLS-1:0] cell_mode,
  input  wire logic [CELLS-1:0]       clear_line_sel,
  input  wire logic [CELLS-1:0]       load_value_input,
  input  wire logic [CELLS-1:0]       cell_d,
  output logic [CELLS-1:0]            cell_q
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nxt_rst_meta_ff;
  logic nxt_rst_sync_ff;

  always_comb begin
    nxt_rst_meta_ff = `CRAC_RST_RELEASE;
    nxt_rst_sync_ff = rst_meta_ff;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= `CRAC_RST_VALUE;
      rst_sync_ff <= `CRAC_RST_VALUE;
    end else begin
      rst_meta_ff <= nxt_rst_meta_ff;
      rst_sync_ff <= nxt_rst_sync_ff;
    end
  end

  // ****************************************************************
  // Line and load term helpers
  // ****************************************************************
  // Picks the control line that a clear-only or inverted preset cell
  // listens to
  function automatic logic pick_line(
    input logic sel_b,
    input logic line_a,
    input logic line_b
  );
    pick_line = (sel_b == `CRAC_SEL_LINE_B) ? line_b : line_a;
  endfunction : pick_line

  // A one is loaded through the preset pin of the store
  function automatic logic load_set(
    input logic line,
    input logic load_val
  );
    load_set = line & load_val;
  endfunction : load_set

  // A zero is loaded through the clear pin of the store
  function automatic logic load_reset(
    input logic line,
    input logic load_val
  );
    load_reset = line & ~load_val;
  endfunction : load_reset

  // Pins are active low, so an idle request leaves the pin high
  function automatic logic active_low(
    input logic req
  );
    active_low = ~req;
  endfunction : active_low

  // Modes that keep the complement of the observed bit in the store
  function automatic logic mode_inverted(
    input crac_mode_e mode
  );
    logic inv;
    inv = 1'b0;
    case (mode)
      crac_mode_preset_inv: begin
        inv = 1'b1;
      end
      crac_mode_load_pre: begin
        inv = 1'b1;
      end
      default: begin
        inv = 1'b0;
      end
    endcase
    mode_inverted = inv;
  endfunction : mode_inverted

  // ****************************************************************
  // Store side requests
  // ****************************************************************
  // Requests are taken as the store sees them, before the inversion
  // of the inverted modes is folded in.
  // A line that the mode does not use gives no request.
  function automatic logic store_clear_req(
    input crac_mode_e mode,
    input logic       line_a,
    input logic       line_b,
    input logic       sel_b,
    input logic       load_val
  );
    logic req;
    req = 1'b0;
    case (mode)
      crac_mode_none: begin
        req = 1'b0;
      end
      crac_mode_clear: begin
        req = pick_line(sel_b, line_a, line_b);
      end
      crac_mode_preset_load: begin
        req = 1'b0;
      end
      crac_mode_preset_inv: begin
        req = pick_line(sel_b, line_a, line_b);
      end
      crac_mode_clr_pre: begin
        req = line_b;
      end
      crac_mode_load_clr: begin
        req = load_reset(line_a, load_val) | line_b;
      end
      crac_mode_load_pre: begin
        req = load_reset(line_a, load_val) | line_b;
      end
      crac_mode_load_only: begin
        req = load_reset(line_a, load_val);
      end
      default: begin
        req = 1'b0;
      end
    endcase
    store_clear_req = req;
  endfunction : store_clear_req

  // Line b never presets the store; in the inverted modes its effect
  // shows as a preset only after the swap below.
  function automatic logic store_preset_req(
    input crac_mode_e mode,
    input logic       line_a,
    input logic       load_val
  );
    logic req;
    req = 1'b0;
    case (mode)
      crac_mode_none: begin
        req = 1'b0;
      end
      crac_mode_clear: begin
        req = 1'b0;
      end
      crac_mode_preset_load: begin
        // Load value tied high inside the cell, the input is not used
        req = line_a;
      end
      crac_mode_preset_inv: begin
        // Preset comes from the store clear, the load value stays free
        req = 1'b0;
      end
      crac_mode_clr_pre: begin
        req = line_a;
      end
      crac_mode_load_clr: begin
        req = load_set(line_a, load_val);
      end
      crac_mode_load_pre: begin
        // Driving logic already presents the inverted load value
        req = load_set(line_a, load_val);
      end
      crac_mode_load_only: begin
        req = load_set(line_a, load_val);
      end
      default: begin
        req = 1'b0;
      end
    endcase
    store_preset_req = req;
  endfunction : store_preset_req

  // ****************************************************************
  // Priority, inversion and reset terms
  // ****************************************************************
  // Clear beats preset, so a cell never sees both pins low
  function automatic logic clear_first(
    input logic clr_req,
    input logic pre_req
  );
    clear_first = pre_req & ~clr_req;
  endfunction : clear_first

  // Inverted storage is folded in: clearing the store sets the
  // observed bit, so the flop keeps the observed value and no gate
  // sits after it, which keeps the output straight from a flop.
  function automatic logic swap_if(
    input logic inv,
    input logic keep,
    input logic other
  );
    swap_if = inv ? other : keep;
  endfunction : swap_if

  // Reset copy forces a clear and blocks any preset
  function automatic logic gate_clear(
    input logic req,
    input logic rst_on
  );
    gate_clear = req | rst_on;
  endfunction : gate_clear

  function automatic logic gate_preset(
    input logic req,
    input logic rst_on
  );
    gate_preset = req & ~rst_on;
  endfunction : gate_preset

  // ****************************************************************
  // Per cell request stages
  // ****************************************************************
  // The controls reach the asynchronous pins without a register on
  // purpose: asynchronous load must act without a clock edge, so any
  // glitch on the control lines is seen by the cell, as in the fabric.
  logic [CELLS-1:0] cell_inv;
  logic [CELLS-1:0] store_clr;
  logic [CELLS-1:0] store_pre_raw;
  logic [CELLS-1:0] store_pre;
  logic [CELLS-1:0] obs_clr;
  logic [CELLS-1:0] obs_pre;
  logic [CELLS-1:0] clear_low;
  logic [CELLS-1:0] preset_low;
  logic             in_reset;

  // Lines are shared by the cluster, mode and load value are per cell
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      cell_inv[i]      = mode_inverted(cell_mode[i]);
      store_clr[i]     = store_clear_req(cell_mode[i], cluster_ctrl_a, cluster_ctrl_b,
                                         clear_line_sel[i], load_value_input[i]);
      store_pre_raw[i] = store_preset_req(cell_mode[i], cluster_ctrl_a, load_value_input[i]);
    end
  end

  // Priority is settled on the store side, before the swap, so that
  // line b wins in the inverted modes as well
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      store_pre[i] = clear_first(store_clr[i], store_pre_raw[i]);
      obs_clr[i]   = swap_if(cell_inv[i], store_clr[i], store_pre[i]);
      obs_pre[i]   = swap_if(cell_inv[i], store_pre[i], store_clr[i]);
    end
  end

  // ****************************************************************
  // Reset gating and pin levels
  // ****************************************************************
  // The synchronised reset copy holds every cell clear, so no cell
  // leaves reset with a preset already applied.
  always_comb begin
    in_reset = ~rst_sync_ff;
    for (int i = 0; i < CELLS; i++) begin
      clear_low[i]  = active_low(gate_clear(obs_clr[i], in_reset));
      preset_low[i] = active_low(gate_preset(obs_pre[i], in_reset));
    end
  end

  for (genvar g = 0; g < CELLS; g++) begin : g_cell
    crac_cell_ff u_cell (
      .clock      (clock),
      .clear_low  (clear_low[g]),
      .preset_low (preset_low[g]),
      .d          (cell_d[g]),
      .q          (cell_q[g])
    );
  end

endmodule : crac_ctrl
`default_nettype wire

// ===== tb/crac_ctrl_monitor.sv
// Assertion checker for the cell register control block
`timescale 1ns/10ps
`default_nettype none
module crac_ctrl_monitor
  import crac_pkg::*;
#(parameter int CELLS = 8) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   cluster_ctrl_a,
  input wire logic                   cluster_ctrl_b,
  input wire crac_mode_e [CELLS-1:0] cell_mode,
  input wire logic [CELLS-1:0]       clear_line_sel,
  input wire logic [CELLS-1:0]       load_value_input,
  input wire logic [CELLS-1:0]       cell_d,
  input wire logic [CELLS-1:0]       cell_q
);
  logic [1:0] age_ff;
  logic [1:0] nxt_age;
  wire        a = cluster_ctrl_a;
  wire        b = cluster_ctrl_b;
  wire        q = cell_q[0];
  wire        lv = load_value_input[0];
  wire        sl = clear_line_sel[0] ? b : a;
  crac_mode_e m;
  assign m = cell_mode[0];
  // Async controls only act once the internal reset copy is high
  always_comb begin
    nxt_age = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) age_ff <= 2'h0;
    else age_ff <= nxt_age;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || age_ff != 2'h3);
  sequence s_quiet;
    m == crac_mode_none;
  endsequence
  a_clear_zero: assert property (m == crac_mode_clear && sl |-> !q)
    else $error("clear did not force zero");
  a_inv_preset_one: assert property (m == crac_mode_preset_inv && sl |-> q)
    else $error("inverted preset did not read one");
  a_preset_load_one: assert property (m == crac_mode_preset_load && a |-> q)
    else $error("preset load did not read one");
  a_clr_pre_lines: assert property (m == crac_mode_clr_pre && (a || b) |-> q == !b)
    else $error("clear and preset mode wrong");
  a_load_clr_lines: assert property (m == crac_mode_load_clr && (a || b) |-> q == (lv && !b))
    else $error("load with clear mode wrong");
  a_load_pre_lines: assert property (m == crac_mode_load_pre && (a || b) |-> q == (b || !lv))
    else $error("load with preset mode wrong");
  a_load_only_copy: assert property (m == crac_mode_load_only && a |-> q == lv)
    else $error("load only mode wrong");
  a_d_capture_edge: assert property (s_quiet ##1 s_quiet |-> q == $past(cell_d[0]))
    else $error("register did not take its input");
endmodule : crac_ctrl_monitor
`default_nettype wire

// ===== tb/crac_cell_logic.sv
// Model of the cell logic that feeds the load value input
`timescale 1ns/10ps
`default_nettype none
module crac_cell_logic
  import crac_pkg::*;
#(parameter int CELLS = 8) (
  input  wire crac_mode_e [CELLS-1:0] cell_mode,
  input  wire logic [CELLS-1:0]       want_value,
  output logic [CELLS-1:0]            load_value_input
);
  // Inverted store reads back the complement, so the value goes in inverted
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      load_value_input[i] = (cell_mode[i] == crac_mode_load_pre) ? ~want_value[i] : want_value[i];
    end
  end
endmodule : crac_cell_logic
`default_nettype wire

// ===== tb/crac_ctrl_tb_top.sv
// Testbench top for the cell register control block
`timescale 1ns/10ps
`default_nettype none
module crac_ctrl_tb_top;
  import crac_pkg::*;
  logic             clock, rst_n, ctl_a, ctl_b;
  crac_mode_e [7:0] mode;
  logic [7:0]       sel, want, lv, d, q;
  int               failures, checked;
  crac_ctrl #(.CELLS(8)) i_crac_ctrl (.clock(clock), .rst_n(rst_n), .cluster_ctrl_a(ctl_a),
    .cluster_ctrl_b(ctl_b), .cell_mode(mode), .clear_line_sel(sel), .load_value_input(lv),
    .cell_d(d), .cell_q(q));
  crac_cell_logic #(.CELLS(8)) i_crac_cell_logic (.cell_mode(mode), .want_value(want),
    .load_value_input(lv));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task finish_test;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] exp);
    checked++;
    if (q !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, q);
    end
  endtask : chk
  task step(input logic a, input logic b, input logic [7:0] exp);
    @(posedge clock);
    ctl_a <= a;
    ctl_b <= b;
    @(negedge clock);
    chk(exp);
  endtask : step
  // Controls released, then one clean edge loads v through D
  task set_mode(input crac_mode_e m, input logic [7:0] v, input logic [7:0] w);
    @(posedge clock);
    foreach (mode[i]) mode[i] <= m;
    ctl_a <= 1'b0;
    ctl_b <= 1'b0;
    d <= v;
    want <= w;
    @(posedge clock);
    @(negedge clock);
    chk(v);
  endtask : set_mode
  task t_none;
    set_mode(crac_mode_none, 8'h5A, 8'h00);
    step(1'b1, 1'b1, 8'h5A);
  endtask : t_none
  task t_clear;
    set_mode(crac_mode_clear, 8'hFF, 8'h00);
    step(1'b1, 1'b0, 8'hAA);
    step(1'b0, 1'b1, 8'h00);
  endtask : t_clear
  task t_preset_inv;
    set_mode(crac_mode_preset_inv, 8'h00, 8'h0F);
    step(1'b1, 1'b0, 8'h55);
    step(1'b0, 1'b1, 8'hFF);
  endtask : t_preset_inv
  task t_preset_load;
    set_mode(crac_mode_preset_load, 8'h00, 8'h00);
    step(1'b1, 1'b0, 8'hFF);
  endtask : t_preset_load
  task t_clr_pre;
    set_mode(crac_mode_clr_pre, 8'h00, 8'h00);
    step(1'b1, 1'b1, 8'h00);
    step(1'b1, 1'b0, 8'hFF);
    step(1'b0, 1'b1, 8'h00);
  endtask : t_clr_pre
  task t_load_clr;
    set_mode(crac_mode_load_clr, 8'hFF, 8'h3C);
    step(1'b1, 1'b0, 8'h3C);
    step(1'b1, 1'b1, 8'h00);
  endtask : t_load_clr
  task t_load_pre;
    set_mode(crac_mode_load_pre, 8'h00, 8'h3C);
    step(1'b1, 1'b0, 8'h3C);
    step(1'b1, 1'b1, 8'hFF);
  endtask : t_load_pre
  task t_load_only;
    set_mode(crac_mode_load_only, 8'h00, 8'hA5);
    step(1'b0, 1'b1, 8'h00);
    step(1'b1, 1'b1, 8'hA5);
    step(1'b1, 1'b0, 8'hA5);
    @(posedge clock);
    want <= 8'h3C;
    @(negedge clock);
    chk(8'h3C);
  endtask : t_load_only
  // Mid-run reset: clears at once, cells stay clear until the sync copy rises
  task t_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    ctl_a <= 1'b0;
    ctl_b <= 1'b0;
    d     <= 8'h96;
    @(negedge clock);
    chk(8'h00);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(8'h00);
    @(negedge clock);
    chk(8'h96);
  endtask : t_reset
  initial begin
    rst_n = 1'b0;
    ctl_a = 1'b0;
    ctl_b = 1'b0;
    foreach (mode[i]) mode[i] = crac_mode_none;
    sel = 8'hAA;
    want = 8'h00;
    d = 8'hC3;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge clock);
    chk(8'h00);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_none();
    t_clear();
    t_preset_inv();
    t_preset_load();
    t_clr_pre();
    t_load_clr();
    t_load_pre();
    t_load_only();
    t_reset();
    finish_test();
  end
  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule : crac_ctrl_tb_top
bind crac_ctrl crac_ctrl_monitor #(.CELLS(CELLS)) i_crac_ctrl_monitor (.clock(clock), .rst_n(rst_n),
  .cluster_ctrl_a(cluster_ctrl_a), .cluster_ctrl_b(cluster_ctrl_b), .cell_mode(cell_mode),
  .clear_line_sel(clear_line_sel), .load_value_input(load_value_input), .cell_d(cell_d), .cell_q(cell_q));
`default_nettype wire
